// >>> logic/isc_pkg.sv
package isc_pkg;

   // Bus addresses, first byte after a start
   localparam logic [7:0] ISC_ADDR_WR       = 8'hd2;
   localparam logic [7:0] ISC_ADDR_RD       = 8'hd3;

   // Register offsets
   localparam logic [7:0] ISC_REG_CFG       = 8'h00;
   localparam logic [7:0] ISC_REG_SYNTH     = 8'h08;
   localparam logic [7:0] ISC_REG_WORD_HI   = 8'h0b;
   localparam logic [7:0] ISC_REG_WORD_MID  = 8'h0c;
   localparam logic [7:0] ISC_REG_WORD_LO   = 8'h0d;
   localparam logic [7:0] ISC_REG_TX_DATA   = 8'h13;

   // Register file size, offsets at or above read as zero
   localparam int         ISC_DEPTH         = 32;
   localparam logic [7:0] ISC_DEPTH_B       = 8'h20;
   localparam logic [7:0] ISC_REG_RST       = 8'h00;

   // Field positions
   localparam int         ISC_XDIV_LSB      = 4;
   localparam int         ISC_LO_OUTPUT_DIVIDER_LSB     = 4;
   localparam int         ISC_FRAC_BIT      = 0;

   // Crystal divider codes and ratios
   localparam logic [1:0] ISC_XDIV_13M      = 2'h0;
   localparam logic [1:0] ISC_XDIV_16M      = 2'h1;
   localparam logic [1:0] ISC_XDIV_19M2     = 2'h2;
   localparam logic [2:0] ISC_RATIO_13M     = 3'h4;
   localparam logic [2:0] ISC_RATIO_16M     = 3'h5;
   localparam logic [2:0] ISC_RATIO_19M2    = 3'h6;

   // Legal integer part of the synthesizer divide ratio
   localparam logic [7:0] ISC_NDIV_MIN      = 8'h0b;
   localparam logic [7:0] ISC_NDIV_MAX      = 8'h48;

   // Bit counter marks
   localparam logic [3:0] ISC_LAST_BIT      = 4'h7;
   localparam logic [3:0] ISC_TX_DONE       = 4'h8;
   localparam logic [3:0] ISC_ONE           = 4'h1;

   // Synchroniser reset value: scl, sda high, selects low
   localparam logic [3:0] ISC_SYNC_RST      = 4'h3;

   // Slave engine states, Gray along the write path
   typedef enum logic [2:0] {
      ISC_IDLE = 3'h0,
      ISC_ADDR = 3'h1,
      ISC_ACK  = 3'h3,
      ISC_RX   = 3'h2,
      ISC_TX   = 3'h6,
      ISC_MACK = 3'h7
   } isc_state_type;

endpackage

// >>> logic/isc_slave.sv
// Function
// - Bus active only with both selects grounded
// - Nine clocks per byte, eight bits plus acknowledge
// - SDA change during SCL high is control
// - Lines idle high, release outside transfers
// - Detect start and stop conditions
// - Acknowledge: hold SDA low through ninth pulse
// - Not-acknowledge: SDA released high on ninth
// - Answer address bytes 0xd2 and 0xd3
// - Watch start plus address, acknowledge, then direction
// - Write: address, pointer, data, each acknowledged
// - Data bytes travel most significant bit first
// - Burst writes go to successive registers until stop
// - Start crystal oscillator when addressed
// - Divider select codes give ratios 4, 5, 6
// - Carrier word 24 bits at 0x0b..0x0d
// - Sixteen-bit fractional divider, ratio 11 to 72
// - LO divider field drives output divider
// - Fractional bit cleared means integer-N
// - Read: pointer, repeat start, data until NACK
// - Transmit data register does not auto-increment
`timescale 1ns/10ps
`default_nettype none
module isc_slave
   import isc_pkg::*;
(
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // Mode select pins
   input  wire logic        preset_select_pin_0_i,
   input  wire logic        preset_select_pin_1_i,
   // Two-wire bus
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   // Oscillator control
   output logic             crystal_oscillator_enable_o,
   // Crystal divider
   output logic [1:0]       crystal_divider_select_o,
   output logic [2:0]       crystal_divide_ratio_o,
   // Synthesizer configuration
   output logic [23:0]      carrier_frequency_word_o,
   output logic [7:0]       synth_integer_ratio_o,
   output logic [15:0]      synth_fraction_o,
   output logic             synth_ratio_valid_o,
   output logic [1:0]       lo_output_divider_o,
   output logic             fractional_synth_enable_o,
   // Transmit data toward the transmit FIFO
   output logic [7:0]       tx_data_o,
   output logic             tx_data_valid_o,
   // Status
   output logic             bus_enabled_o
);

   // Input synchronisers: first stage read only by the second
   logic [3:0]    meta_r;            // {preset_select_pin_1, preset_select_pin_0, scl, sda}, first stage
   logic [3:0]    sync_r;            // Second stage, safe to use
   logic [1:0]    prev_r;            // Previous scl, sda for edge finding

   // Slave engine state
   isc_state_type state_r, state_nxt;
   logic [3:0]    cnt_r, cnt_nxt;     // SCL rising edges in current byte
   logic [7:0]    sh_r, sh_nxt;       // Shift register, MSB on the wire
   logic [7:0]    ptr_r, ptr_nxt;     // Register pointer
   logic          ptr_phase_r, ptr_phase_nxt; // Next received byte is pointer
   logic          to_tx_r, to_tx_nxt; // After acknowledge, send data
   logic          drive_r, drive_nxt; // Pulling SDA low
   logic          xo_r, xo_nxt;       // Oscillator running
   logic [7:0]    txd_r, txd_nxt;     // Last byte for the transmit FIFO
   logic          txv_r, txv_nxt;     // One-cycle valid for it

   // Register file and its write port
   logic [7:0]    mem_r [ISC_DEPTH];
   logic          wr_en;
   logic [7:0]    wr_data;

   // Decoded bus events
   logic          scl_s;
   logic          sda_s;
   logic          scl_rise;
   logic          scl_fall;
   logic          start_cond;
   logic          stop_cond;
   logic          bus_en;
   logic [7:0]    rd_data;
   logic [7:0]    rx_byte;
   logic [7:0]    ptr_inc;

   // Two flip-flops on every pin, plus one history stage on scl and sda
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= ISC_SYNC_RST;
         sync_r <= ISC_SYNC_RST;
         prev_r <= ISC_SYNC_RST[1:0];
      end else begin
         meta_r <= {preset_select_pin_1_i, preset_select_pin_0_i, scl_i, sda_i};
         sync_r <= meta_r;
         prev_r <= sync_r[1:0];
      end
   end

   // Edge and condition decode on synchronised lines
   assign scl_s      = sync_r[1];
   assign sda_s      = sync_r[0];
   assign scl_rise   = scl_s & ~prev_r[1];
   assign scl_fall   = ~scl_s & prev_r[1];
   assign start_cond = scl_s & prev_r[1] & prev_r[0] & ~sda_s;
   assign stop_cond  = scl_s & prev_r[1] & ~prev_r[0] & sda_s;
   assign bus_en     = ~sync_r[2] & ~sync_r[3];

   // Read data; unmapped offsets answer zero
   assign rd_data = (ptr_r < ISC_DEPTH_B) ? mem_r[ptr_r[4:0]] : ISC_REG_RST;
   // Byte as it stands after the current bit is shifted in
   assign rx_byte = {sh_r[6:0], sda_s};
   // The transmit data register holds the pointer still
   assign ptr_inc = (ptr_r == ISC_REG_TX_DATA) ? ptr_r : 8'(ptr_r + 8'h01);

   // Slave engine next-state logic
   always_comb begin
      state_nxt     = state_r;
      cnt_nxt       = cnt_r;
      sh_nxt        = sh_r;
      ptr_nxt       = ptr_r;
      ptr_phase_nxt = ptr_phase_r;
      to_tx_nxt     = to_tx_r;
      drive_nxt     = drive_r;
      xo_nxt        = xo_r;
      txd_nxt       = txd_r;
      txv_nxt       = 1'b0;
      wr_en         = 1'b0;
      wr_data       = rx_byte;
      if (!bus_en) begin
         // Preset mode: never touch the bus
         state_nxt = ISC_IDLE;
         drive_nxt = 1'b0;
      end else if (start_cond) begin
         // Start or repeated start: pointer is kept for reads
         state_nxt = ISC_ADDR;
         cnt_nxt   = 4'h0;
         drive_nxt = 1'b0;
      end else if (stop_cond) begin
         // Stop ends everything and frees the line
         state_nxt = ISC_IDLE;
         drive_nxt = 1'b0;
      end else begin
         case (state_r)
            ISC_IDLE: begin
               // Waiting for a start
               drive_nxt = 1'b0;
            end
            ISC_ADDR: begin
               // Collect address byte on rising edges
               if (scl_rise) begin
                  sh_nxt  = rx_byte;
                  cnt_nxt = 4'(cnt_r + ISC_ONE);
                  if (cnt_r == ISC_LAST_BIT) begin
                     if (rx_byte == ISC_ADDR_WR || rx_byte == ISC_ADDR_RD) begin
                        state_nxt     = ISC_ACK;
                        to_tx_nxt     = rx_byte[0];
                        ptr_phase_nxt = ~rx_byte[0];
                        xo_nxt        = 1'b1;
                     end else begin
                        // Someone else's address: stay silent until next start
                        state_nxt = ISC_IDLE;
                     end
                  end
               end
            end
            ISC_ACK: begin
               // Pull low at the fall after bit 8, free at the fall after bit 9
               if (scl_fall) begin
                  if (!drive_r) begin
                     drive_nxt = 1'b1;
                  end else if (to_tx_r) begin
                     // Hand over straight into the first data bit
                     state_nxt = ISC_TX;
                     sh_nxt    = rd_data;
                     drive_nxt = ~rd_data[7];
                     cnt_nxt   = 4'h0;
                     ptr_nxt   = ptr_inc;
                  end else begin
                     state_nxt = ISC_RX;
                     drive_nxt = 1'b0;
                     cnt_nxt   = 4'h0;
                  end
               end
            end
            ISC_RX: begin
               // Pointer byte or data byte from the master
               if (scl_rise) begin
                  sh_nxt  = rx_byte;
                  cnt_nxt = 4'(cnt_r + ISC_ONE);
                  if (cnt_r == ISC_LAST_BIT) begin
                     state_nxt = ISC_ACK;
                     to_tx_nxt = 1'b0;
                     if (ptr_phase_r) begin
                        ptr_nxt       = rx_byte;
                        ptr_phase_nxt = 1'b0;
                     end else begin
                        // Store, then acknowledge once stored
                        wr_en   = (ptr_r < ISC_DEPTH_B);
                        ptr_nxt = ptr_inc;
                        if (ptr_r == ISC_REG_TX_DATA) begin
                           txd_nxt = rx_byte;
                           txv_nxt = 1'b1;
                        end
                     end
                  end
               end
            end
            ISC_TX: begin
               // Send a byte; a 1 bit means release the line
               if (scl_rise) begin
                  cnt_nxt = 4'(cnt_r + ISC_ONE);
               end else if (scl_fall) begin
                  if (cnt_r == ISC_TX_DONE) begin
                     // Let the master answer on the ninth pulse
                     state_nxt = ISC_MACK;
                     drive_nxt = 1'b0;
                     cnt_nxt   = 4'h0;
                  end else begin
                     sh_nxt    = {sh_r[6:0], 1'b0};
                     drive_nxt = ~sh_r[6];
                  end
               end
            end
            ISC_MACK: begin
               // Master acknowledge continues, not-acknowledge ends the read
               if (scl_rise) begin
                  if (sda_s) begin
                     state_nxt = ISC_IDLE;
                  end else begin
                     cnt_nxt = ISC_ONE;
                  end
               end else if (scl_fall && cnt_r == ISC_ONE) begin
                  state_nxt = ISC_TX;
                  sh_nxt    = rd_data;
                  drive_nxt = ~rd_data[7];
                  cnt_nxt   = 4'h0;
                  ptr_nxt   = ptr_inc;
               end
            end
            default: begin
               state_nxt = ISC_IDLE;
               drive_nxt = 1'b0;
            end
         endcase
      end
   end

   // Slave engine registers
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_r     <= ISC_IDLE;
         cnt_r       <= 4'h0;
         sh_r        <= 8'h00;
         ptr_r       <= 8'h00;
         ptr_phase_r <= 1'b0;
         to_tx_r     <= 1'b0;
         drive_r     <= 1'b0;
         xo_r        <= 1'b0;
         txd_r       <= 8'h00;
         txv_r       <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         sh_r        <= sh_nxt;
         ptr_r       <= ptr_nxt;
         ptr_phase_r <= ptr_phase_nxt;
         to_tx_r     <= to_tx_nxt;
         drive_r     <= drive_nxt;
         xo_r        <= xo_nxt;
         txd_r       <= txd_nxt;
         txv_r       <= txv_nxt;
      end
   end

   // Register file; reserved bits are simply stored and read back
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < ISC_DEPTH; i++) begin
            mem_r[i] <= ISC_REG_RST;
         end
      end else if (wr_en) begin
         mem_r[ptr_r[4:0]] <= wr_data;
      end
   end

   // Open drain: only ever pulls low
   assign sda_o    = 1'b0;
   assign sda_oe_o = drive_r;

   // Crystal divider decode; the spare code falls back to 16 MHz
   always_comb begin
      crystal_divider_select_o = mem_r[ISC_REG_CFG[4:0]][ISC_XDIV_LSB +: 2];
      case (crystal_divider_select_o)
         ISC_XDIV_13M:  crystal_divide_ratio_o = ISC_RATIO_13M;
         ISC_XDIV_16M:  crystal_divide_ratio_o = ISC_RATIO_16M;
         ISC_XDIV_19M2: crystal_divide_ratio_o = ISC_RATIO_19M2;
         default:       crystal_divide_ratio_o = ISC_RATIO_16M;
      endcase
   end

   // Synthesizer view of the configuration
   assign carrier_frequency_word_o  = {mem_r[ISC_REG_WORD_HI[4:0]],
                                       mem_r[ISC_REG_WORD_MID[4:0]],
                                       mem_r[ISC_REG_WORD_LO[4:0]]};
   assign fractional_synth_enable_o = mem_r[ISC_REG_SYNTH[4:0]][ISC_FRAC_BIT];
   assign lo_output_divider_o       = mem_r[ISC_REG_SYNTH[4:0]][ISC_LO_OUTPUT_DIVIDER_LSB +: 2];
   assign synth_integer_ratio_o     = carrier_frequency_word_o[23:16];
   // Integer-N drops the fraction so the modulator sees zero
   assign synth_fraction_o          = fractional_synth_enable_o ?
                                      carrier_frequency_word_o[15:0] : 16'h0000;
   assign synth_ratio_valid_o       = (synth_integer_ratio_o >= ISC_NDIV_MIN) &&
                                      (synth_integer_ratio_o <= ISC_NDIV_MAX);

   // Status and side outputs
   assign crystal_oscillator_enable_o = xo_r;
   assign tx_data_o                   = txd_r;
   assign tx_data_valid_o             = txv_r;
   assign bus_enabled_o               = bus_en;

endmodule
`default_nettype wire

// >>> test/isc_slave_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module isc_slave_checker
   import isc_pkg::*;
(
   // Clock and reset
   input wire logic        clock_i,
   input wire logic        rst_i,
   // Pins
   input wire logic        preset_select_pin_0_i,
   input wire logic        preset_select_pin_1_i,
   input wire logic        scl_i,
   input wire logic        sda_oe_o,
   // Configuration and status
   input wire logic        crystal_oscillator_enable_o,
   input wire logic [1:0]  crystal_divider_select_o,
   input wire logic [2:0]  crystal_divide_ratio_o,
   input wire logic [23:0] carrier_frequency_word_o,
   input wire logic [7:0]  synth_integer_ratio_o,
   input wire logic [15:0] synth_fraction_o,
   input wire logic        synth_ratio_valid_o,
   input wire logic        fractional_synth_enable_o,
   input wire logic        tx_data_valid_o,
   input wire logic        bus_enabled_o
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // Six cycles leave room for the pin synchroniser and the registered enable
   property p_bus_off;
      (preset_select_pin_0_i || preset_select_pin_1_i) [*6] |-> !bus_enabled_o && !sda_oe_o;
   endproperty
   property p_cfg_quiet;
      $changed(carrier_frequency_word_o) |-> bus_enabled_o;
   endproperty
   // Code 11 is unused and reads as the 16 MHz ratio
   property p_ratio;
      crystal_divide_ratio_o == ((crystal_divider_select_o == ISC_XDIV_19M2) ? ISC_RATIO_19M2 :
         (crystal_divider_select_o == ISC_XDIV_13M) ? ISC_RATIO_13M : ISC_RATIO_16M);
   endproperty
   property p_int;
      synth_integer_ratio_o == carrier_frequency_word_o[23:16];
   endproperty
   property p_frac;
      synth_fraction_o == (fractional_synth_enable_o ? carrier_frequency_word_o[15:0] : 16'h0000);
   endproperty
   property p_valid;
      synth_ratio_valid_o == (synth_integer_ratio_o >= ISC_NDIV_MIN &&
         synth_integer_ratio_o <= ISC_NDIV_MAX);
   endproperty
   property p_xo;
      crystal_oscillator_enable_o |=> crystal_oscillator_enable_o;
   endproperty
   property p_tx;
      tx_data_valid_o |=> !tx_data_valid_o;
   endproperty
   // The device may only move SDA while the clock is low
   property p_oe;
      $changed(sda_oe_o) |-> !scl_i;
   endproperty
   a_bus_off: assert property (p_bus_off) else $error("port active while deselected");
   a_cfg_quiet: assert property (p_cfg_quiet) else $error("word moved while off");
   a_ratio: assert property (p_ratio) else $error("wrong crystal divide ratio");
   a_int: assert property (p_int) else $error("wrong integer ratio");
   a_frac: assert property (p_frac) else $error("wrong fraction");
   a_valid: assert property (p_valid) else $error("wrong ratio valid flag");
   a_xo: assert property (p_xo) else $error("oscillator enable dropped");
   a_tx: assert property (p_tx) else $error("long transmit data pulse");
   a_oe: assert property (p_oe) else $error("SDA moved during SCL high");
   c_ack: cover property ($rose(sda_oe_o));
   c_xo: cover property ($rose(crystal_oscillator_enable_o));
   c_tx: cover property (tx_data_valid_o);
endmodule
bind isc_slave isc_slave_checker chk (
   .clock_i                     (clock_i),
   .rst_i                       (rst_i),
   .preset_select_pin_0_i       (preset_select_pin_0_i),
   .preset_select_pin_1_i       (preset_select_pin_1_i),
   .scl_i                       (scl_i),
   .sda_oe_o                    (sda_oe_o),
   .crystal_oscillator_enable_o (crystal_oscillator_enable_o),
   .crystal_divider_select_o    (crystal_divider_select_o),
   .crystal_divide_ratio_o      (crystal_divide_ratio_o),
   .carrier_frequency_word_o    (carrier_frequency_word_o),
   .synth_integer_ratio_o       (synth_integer_ratio_o),
   .synth_fraction_o            (synth_fraction_o),
   .synth_ratio_valid_o         (synth_ratio_valid_o),
   .fractional_synth_enable_o   (fractional_synth_enable_o),
   .tx_data_valid_o             (tx_data_valid_o),
   .bus_enabled_o               (bus_enabled_o)
);
`default_nettype wire

// >>> test/isc_i2c_master.sv
`timescale 1ns/10ps
`default_nettype none
module isc_i2c_master (
   // Bench clock, for alignment only
   input  wire logic clock_i,
   // Bus wires
   input  wire logic sda_i,
   output var  logic scl_o,
   output var  logic sda_low_o
);
   // Quarter bit; low phase of three quarters gives the slave time to turn SDA
   localparam time Q = 40ns;
   // Both lines released at idle
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // One bit: data set while SCL low, sampled mid high
   task automatic put_bit(input logic b, output logic s);
      #Q sda_low_o = ~b;
      #(2 * Q) scl_o = 1'b1;
      #(Q / 2) s = sda_i;
      #(Q / 2) scl_o = 1'b0;
   endtask
   // Start or repeated start
   task automatic start();
      @(negedge clock_i);
      #Q sda_low_o = 1'b0;
      #(2 * Q) scl_o = 1'b1;
      #Q sda_low_o = 1'b1;
      #Q scl_o = 1'b0;
   endtask
   task automatic stop();
      #Q sda_low_o = 1'b1;
      #(2 * Q) scl_o = 1'b1;
      #Q sda_low_o = 1'b0;
      #Q;
   endtask
   // Byte out, MSB first, then ninth clock with SDA released
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(d[i], s);
      put_bit(1'b1, s);
      ack = ~s;
   endtask
   // Byte in; last byte answered with a NACK
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
      put_bit(last, s);
   endtask
endmodule
`default_nettype wire

// >>> test/isc_slave_test.sv
`timescale 1ns/10ps
`default_nettype none
module isc_slave_test
   import isc_pkg::*;
;
   // Design pins
   logic        clock_i;
   logic        rst_i;
   logic        preset_select_pin_0_i;
   logic        preset_select_pin_1_i;
   logic        scl_i;
   logic        sda_i;
   logic        sda_o;
   logic        sda_oe_o;
   logic        crystal_oscillator_enable_o;
   logic [1:0]  crystal_divider_select_o;
   logic [2:0]  crystal_divide_ratio_o;
   logic [23:0] carrier_frequency_word_o;
   logic [7:0]  synth_integer_ratio_o;
   logic [15:0] synth_fraction_o;
   logic        synth_ratio_valid_o;
   logic [1:0]  lo_output_divider_o;
   logic        fractional_synth_enable_o;
   logic [7:0]  tx_data_o;
   logic        tx_data_valid_o;
   logic        bus_enabled_o;
   // Bench state
   logic        sda_low;
   int          err_count = 0;
   int          checks_done = 0;
   int          tx_pulses = 0;
   // Open-drain wire: low if anyone pulls, pull-up otherwise
   assign sda_i = sda_low ? 1'b0 : (sda_oe_o ? sda_o : 1'b1);
   isc_slave dut (
      .clock_i                     (clock_i),
      .rst_i                       (rst_i),
      .preset_select_pin_0_i       (preset_select_pin_0_i),
      .preset_select_pin_1_i       (preset_select_pin_1_i),
      .scl_i                       (scl_i),
      .sda_i                       (sda_i),
      .sda_o                       (sda_o),
      .sda_oe_o                    (sda_oe_o),
      .crystal_oscillator_enable_o (crystal_oscillator_enable_o),
      .crystal_divider_select_o    (crystal_divider_select_o),
      .crystal_divide_ratio_o      (crystal_divide_ratio_o),
      .carrier_frequency_word_o    (carrier_frequency_word_o),
      .synth_integer_ratio_o       (synth_integer_ratio_o),
      .synth_fraction_o            (synth_fraction_o),
      .synth_ratio_valid_o         (synth_ratio_valid_o),
      .lo_output_divider_o         (lo_output_divider_o),
      .fractional_synth_enable_o   (fractional_synth_enable_o),
      .tx_data_o                   (tx_data_o),
      .tx_data_valid_o             (tx_data_valid_o),
      .bus_enabled_o               (bus_enabled_o)
   );
   isc_i2c_master m (.clock_i(clock_i), .sda_i(sda_i), .scl_o(scl_i), .sda_low_o(sda_low));
   // Clock, 20 ns
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   // Counts transmit data strobes
   always @(posedge clock_i) begin
      if (tx_data_valid_o === 1'b1) tx_pulses++;
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Register write: last n bytes of d, high byte first
   task automatic wr_regs(input logic [7:0] ptr, input int n, input logic [23:0] d);
      logic a;
      m.start();
      m.wr_byte(ISC_ADDR_WR, a);
      chk(a, 1'b1);
      m.wr_byte(ptr, a);
      chk(a, 1'b1);
      for (int i = n - 1; i >= 0; i--) begin
         m.wr_byte(d[8 * i +: 8], a);
         chk(a, 1'b1);
      end
      m.stop();
   endtask
   task automatic rd_regs(input logic [7:0] ptr, input int n, output logic [23:0] d);
      logic a;
      logic [7:0] b;
      d = 24'h000000;
      m.start();
      m.wr_byte(ISC_ADDR_WR, a);
      m.wr_byte(ptr, a);
      m.start();
      m.wr_byte(ISC_ADDR_RD, a);
      chk(a, 1'b1);
      for (int i = n - 1; i >= 0; i--) begin
         m.rd_byte(i == 0, b);
         d[8 * i +: 8] = b;
      end
      m.stop();
   endtask
   task automatic t_reset();
      chk(carrier_frequency_word_o, 24'h000000);
      chk(crystal_divide_ratio_o, ISC_RATIO_13M);
      chk({crystal_oscillator_enable_o, sda_oe_o, tx_data_valid_o}, 3'h0);
      chk(bus_enabled_o, 1'b1);
      $display("test reset done");
   endtask
   // Foreign address is ignored, the retry is taken
   task automatic t_addr();
      logic a;
      m.start();
      m.wr_byte(8'hd4, a);
      m.stop();
      chk(a, 1'b0);
      chk(crystal_oscillator_enable_o, 1'b0);
      wr_regs(ISC_REG_CFG, 1, 24'h000000);
      chk(crystal_oscillator_enable_o, 1'b1);
      $display("test address done");
   endtask
   task automatic t_word();
      logic [23:0] d;
      wr_regs(ISC_REG_WORD_HI, 3, 24'h123457);
      chk(carrier_frequency_word_o, 24'h123457);
      chk(synth_fraction_o, 16'h0000);
      for (int c = 0; c < 4; c++) begin
         wr_regs(ISC_REG_SYNTH, 1, 24'(c * 16 + 1));
         chk(lo_output_divider_o, 24'(c));
         chk({fractional_synth_enable_o, synth_fraction_o}, 17'h13457);
      end
      wr_regs(ISC_REG_SYNTH, 1, 24'h000000);
      chk({fractional_synth_enable_o, synth_fraction_o}, 17'h00000);
      rd_regs(ISC_REG_WORD_HI, 3, d);
      chk(d, 24'h123457);
      $display("test word done");
   endtask
   task automatic t_div();
      // Spare code 11 is expected to fall back to the 16 MHz ratio
      for (int c = 0; c < 4; c++) begin
         wr_regs(ISC_REG_CFG, 1, 24'(c * 16));
         chk(crystal_divider_select_o, 24'(c));
         chk(crystal_divide_ratio_o, (c == 3) ? 24'(ISC_RATIO_16M) : 24'(c + 4));
      end
      $display("test divider done");
   endtask
   // Integer ratio just outside and on both ends of the legal span
   task automatic t_ratio();
      for (int i = 0; i < 4; i++) begin
         wr_regs(ISC_REG_WORD_HI, 1, 24'(i < 2 ? 10 + i : 70 + i));
         chk(synth_integer_ratio_o, 24'(i < 2 ? 10 + i : 70 + i));
         chk(synth_ratio_valid_o, 24'(i == 1 || i == 2));
      end
      $display("test ratio done");
   endtask
   // Pointer stays on the transmit register, so 0x14 is left untouched
   task automatic t_tx();
      logic [23:0] d;
      int          base;
      // Strobe counter is owned by its own process; only a baseline is taken here
      base = tx_pulses;
      wr_regs(ISC_REG_TX_DATA, 2, 24'h00a53c);
      chk(tx_data_o, 24'h00003c);
      chk(24'(tx_pulses - base), 24'h000002);
      rd_regs(8'h14, 1, d);
      chk(d, 24'h000000);
      $display("test transmit data done");
   endtask
   task automatic t_off();
      logic a;
      for (int p = 0; p < 2; p++) begin
         @(negedge clock_i);
         {preset_select_pin_1_i, preset_select_pin_0_i} = 2'(1 << p);
         repeat (4) @(negedge clock_i);
         chk(bus_enabled_o, 1'b0);
         m.start();
         m.wr_byte(ISC_ADDR_WR, a);
         m.stop();
         chk(a, 1'b0);
         {preset_select_pin_1_i, preset_select_pin_0_i} = 2'h0;
         repeat (4) @(negedge clock_i);
         chk(bus_enabled_o, 1'b1);
      end
      $display("test disable done");
   endtask
   task automatic test_done();
      $display("%0d checks, %0d mismatches", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Run takes about a hundred microseconds; 1 ms means a hang
   initial begin
      #1ms;
      err_count++;
      $display("mismatch at %0t: run timed out", $time);
      test_done();
   end
   initial begin
      rst_i = 1'b1;
      preset_select_pin_0_i = 1'b0;
      preset_select_pin_1_i = 1'b0;
      repeat (10) @(negedge clock_i);
      rst_i = 1'b0;
      repeat (4) @(negedge clock_i);
      t_reset();
      t_addr();
      t_word();
      t_div();
      t_ratio();
      t_tx();
      t_off();
      test_done();
   end
endmodule
`default_nettype wire
